// ### design/cpic_nmi.sv
// NMI detect latches, source control and global mask
`timescale 1ns/1ps
module cpic_nmi (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic serr_n,
  input wire logic channel_check_n,
  cpic_nmi_if.unit bus,
  output logic nmi
);
  import cpic_pkg::*;

  typedef struct packed {
    logic serr_en;
    logic chk_en;
    logic serr_st;
    logic chk_st;
    logic masked;
    logic [6:0] rtc_addr;
    logic nmi;
  } cpic_nmi_st_type;

  cpic_nmi_st_type s_q;
  cpic_nmi_st_type s_d;

  //////////////////////////////////////////////////////////////////////
  // Next state: a disabled source drops its latch, otherwise latches hold
  always_comb begin
    s_d = s_q;
    if (bus.ctl_wr) begin
      s_d.serr_en = bus.wdata[CPIC_NMI_SERR_EN];
      s_d.chk_en = bus.wdata[CPIC_NMI_CHK_EN];
    end
    if (bus.mask_wr) begin
      s_d.masked = bus.wdata[CPIC_NMI_MASK_BIT];
      s_d.rtc_addr = bus.wdata[6:0];
    end
    s_d.serr_st = s_d.serr_en & (s_q.serr_st | ~serr_n);
    s_d.chk_st = s_d.chk_en & (s_q.chk_st | ~channel_check_n);
    // Mask gates only the output, so unmask re-raises a pending NMI
    s_d.nmi = ~s_q.masked & (s_q.serr_st | s_q.chk_st);
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.masked <= 1'b1;
      s_q.rtc_addr <= CPIC_RTC_ADDR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Read views of the two byte registers
  always_comb begin
    bus.ctl_rd = 8'h00;
    bus.ctl_rd[CPIC_NMI_SERR_EN] = s_q.serr_en;
    bus.ctl_rd[CPIC_NMI_CHK_EN] = s_q.chk_en;
    bus.ctl_rd[CPIC_NMI_CHK_ST] = s_q.chk_st;
    bus.ctl_rd[CPIC_NMI_SERR_ST] = s_q.serr_st;
    bus.mask_rd = {s_q.masked, s_q.rtc_addr};
  end

  assign nmi = s_q.nmi;

  //////////////////////////////////////////////////////////////////////
  a_nmi_serr_fire: assert property (@(posedge core_clk) disable iff (!nrst)
    (!serr_n && s_q.serr_en && !s_q.masked && !bus.ctl_wr && !bus.mask_wr)
    |-> ##2 nmi) else $error("serr did not raise nmi");
  a_nmi_mask_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
    s_q.masked |=> !nmi) else $error("nmi while masked");
  a_nmi_latch_kept: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_q.chk_st && !bus.ctl_wr) |=> s_q.chk_st)
    else $error("channel check latch lost");
endmodule : cpic_nmi

// ### design/cpic_top.sv
// Two cascaded interrupt cores with trigger sense select and NMI
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Two cascaded cores give sixteen request lines
// - Master serves lines 7-0, slave 15-8
// - Master line 2 is cascade; 0 is timer
// - Reset: edge sense, normal EOI, cascaded
// - Each core programmed on its own
// - Divisor bit 5 selects internal coprocessor request
// - Divisor bit 4 selects internal mouse request
// - Per-line trigger sense registers at 4d0, 4d1
// - Bank level-trigger bit in init word ignored
// - Sense 0: rising edge only, no repeat
// - Sense 1: low level requests, no edge
// - Vanished request acknowledges as default line 7
// - Default line 7 leaves in-service clear
// - PCI system error low raises NMI
// - Channel check low raises NMI
// - Two byte registers for NMI
// - Port 70 bit 7 masks; latches kept
// - Mask then unmask gives fresh NMI edge
// - NMI outranks all maskable requests
module cpic_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire cpic_pkg::cpic_addr_type io_addr,
  input wire cpic_pkg::cpic_byte_type io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output cpic_pkg::cpic_byte_type io_rdata,
  input wire logic [15:0] ext_irq,
  input wire logic tmr0_out,
  input wire logic coproc_error_request_pin,
  input wire logic mouse_request,
  input wire logic cop_err_int,
  input wire logic mouse_int,
  input wire cpic_pkg::cpic_byte_type isa_clk_div,
  input wire logic serr_n,
  input wire logic channel_check_n,
  input wire logic interrupt_acknowledge_n,
  output logic intr,
  output cpic_pkg::cpic_byte_type ack_vector,
  output logic ack_vector_oe,
  output logic nmi
);
  import cpic_pkg::*;

  typedef struct packed {
    logic [1:0][7:0] lat;
    logic [1:0][7:0] imr;
    logic [1:0][7:0] insvc;
    logic [1:0][7:0] sense;
    logic [1:0][4:0] vbase;
    cpic_step_type [1:0] step;
    logic [1:0] need4;
    logic [1:0] single;
    logic [1:0] aeoi;
    logic [1:0] rd_insvc;
    logic [15:0] prev;
    logic ack_n_prev;
    logic second;
    logic intr;
    logic oe;
    logic [7:0] vec;
    logic [7:0] rdata;
  } cpic_st_type;

  cpic_st_type s_q;
  cpic_st_type s_d;
  logic [15:0] raw;
  logic [1:0][7:0] pend;
  logic [1:0][7:0] elig;
  logic ack_first;
  logic ack_second;
  cpic_nmi_if nb ();

  //////////////////////////////////////////////////////////////////////
  // Lowest set index wins; top bit says something was found
  function automatic logic [3:0] pick(input logic [7:0] v);
    pick = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        pick = {1'b1, 3'(i)};
      end
    end
  endfunction : pick

  // Lines that outrank every in-service line (fully nested)
  function automatic logic [7:0] above(input logic [7:0] busy);
    logic blk;
    blk = 1'b0;
    for (int i = 0; i < 8; i++) begin
      above[i] = ~blk & ~busy[i];
      blk = blk | busy[i];
    end
  endfunction : above

  // Port of core c: kind 0 command, 1 data, 2 trigger sense
  function automatic cpic_addr_type port_of(input int c,
                                            input logic [1:0] k);
    case (k)
      2'h0: port_of = (c == 0) ? CPIC_MASTER_CMD : CPIC_SLAVE_CMD;
      2'h1: port_of = (c == 0) ? CPIC_MASTER_DATA : CPIC_SLAVE_DATA;
      default: port_of = (c == 0) ? CPIC_SENSE_MASTER : CPIC_SENSE_SLAVE;
    endcase
  endfunction : port_of

  //////////////////////////////////////////////////////////////////////
  // Request sources: timer, routed mouse and coprocessor lines
  always_comb begin
    raw = ext_irq;
    raw[CPIC_IRQ_TIMER] = tmr0_out;
    raw[CPIC_CASCADE_LINE] = 1'b0;
    raw[CPIC_IRQ_MOUSE] = isa_clk_div[CPIC_DIV_MOUSE] ?
                          mouse_int : mouse_request;
    raw[CPIC_IRQ_COP] = isa_clk_div[CPIC_DIV_COP] ?
                        cop_err_int : coproc_error_request_pin;
  end

  // Pending and eligible per core; slave first, it feeds master line 2
  always_comb begin
    pend = '0;
    elig = '0;
    for (int c = 1; c >= 0; c--) begin
      for (int b = 0; b < 8; b++) begin
        pend[c][b] = s_q.sense[c][b] ? ~raw[8*c+b] :
                     s_q.lat[c][b];
      end
      if (c == 0) begin
        pend[0][CPIC_CASCADE_LINE] = |elig[1];
      end
      elig[c] = pend[c] & ~s_q.imr[c] & above(s_q.insvc[c]);
    end
  end

  // Acknowledge pulse edges as seen by the sampled strobe
  assign ack_first = s_q.ack_n_prev & ~interrupt_acknowledge_n & ~s_q.second;
  assign ack_second = s_q.ack_n_prev & ~interrupt_acknowledge_n & s_q.second;

  //////////////////////////////////////////////////////////////////////
  // Next state of both cores, acknowledge sequence and read data
  always_comb begin
    logic [3:0] pm;
    logic [3:0] psl;
    logic [3:0] pe;
    pm = pick(elig[0]);
    psl = pick(elig[1]);
    pe = 4'h0;
    s_d = s_q;
    s_d.prev = raw;
    s_d.ack_n_prev = interrupt_acknowledge_n;
    // Edge latches: a rise sets, a dropped line clears (glitch rejection)
    for (int c = 0; c < 2; c++) begin
      for (int b = 0; b < 8; b++) begin
        if (!raw[8*c+b]) begin
          s_d.lat[c][b] = 1'b0;
        end else if (!s_q.prev[8*c+b] && !s_q.sense[c][b]) begin
          s_d.lat[c][b] = 1'b1;
        end
      end
    end
    // Each core keeps its own programming state
    for (int c = 0; c < 2; c++) begin
      if (io_wr && io_addr == port_of(c, 2'h2)) begin
        s_d.sense[c] = io_wdata;
      end
      if (io_wr && io_addr == port_of(c, 2'h0)) begin
        if (io_wdata[CPIC_IW1_ID]) begin
          // Bank level bit not stored: sense is per line only
          s_d.step[c] = CPIC_IW2;
          s_d.need4[c] = io_wdata[CPIC_IW1_IW4];
          s_d.single[c] = io_wdata[CPIC_IW1_SINGLE];
          s_d.imr[c] = CPIC_IMR_RST;
          s_d.insvc[c] = 8'h00;
          s_d.lat[c] = 8'h00;
          s_d.rd_insvc[c] = 1'b0;
          s_d.aeoi[c] = 1'b0;
        end else if (io_wdata[CPIC_OCW3_ID]) begin
          if (io_wdata[CPIC_OCW3_RR]) begin
            s_d.rd_insvc[c] = io_wdata[CPIC_OCW3_RIS];
          end
        end else if (io_wdata[7:5] == CPIC_EOI_NSPEC) begin
          pe = pick(s_q.insvc[c]);
          if (pe[3]) begin
            s_d.insvc[c][pe[2:0]] = 1'b0;
          end
        end else if (io_wdata[7:5] == CPIC_EOI_SPEC) begin
          s_d.insvc[c][io_wdata[2:0]] = 1'b0;
        end
      end
      if (io_wr && io_addr == port_of(c, 2'h1)) begin
        case (s_q.step[c])
          CPIC_IW2: begin
            s_d.vbase[c] = io_wdata[7:3];
            if (!s_q.single[c]) begin
              s_d.step[c] = CPIC_IW3;
            end else begin
              s_d.step[c] = s_q.need4[c] ? CPIC_IW4 : CPIC_IDLE;
            end
          end
          CPIC_IW3: begin
            s_d.step[c] = s_q.need4[c] ? CPIC_IW4 : CPIC_IDLE;
          end
          CPIC_IW4: begin
            s_d.aeoi[c] = io_wdata[CPIC_IW4_AEOI];
            s_d.step[c] = CPIC_IDLE;
          end
          default: begin
            s_d.imr[c] = io_wdata;
          end
        endcase
      end
    end
    // First pulse freezes the winner; nothing pending means default 7
    if (ack_first) begin
      s_d.second = 1'b1;
      s_d.vec = {s_q.vbase[0], CPIC_DEFAULT_LINE};
      if (pm[3] && pm[2:0] == 3'(CPIC_CASCADE_LINE)) begin
        if (!s_q.aeoi[0]) begin
          s_d.insvc[0][CPIC_CASCADE_LINE] = 1'b1;
        end
        s_d.vec = {s_q.vbase[1], CPIC_DEFAULT_LINE};
        if (psl[3]) begin
          s_d.vec = {s_q.vbase[1], psl[2:0]};
          s_d.lat[1][psl[2:0]] = 1'b0;
          if (!s_q.aeoi[1]) begin
            s_d.insvc[1][psl[2:0]] = 1'b1;
          end
        end
      end else if (pm[3]) begin
        s_d.vec = {s_q.vbase[0], pm[2:0]};
        s_d.lat[0][pm[2:0]] = 1'b0;
        if (!s_q.aeoi[0]) begin
          s_d.insvc[0][pm[2:0]] = 1'b1;
        end
      end
    end
    // Second pulse puts the vector out until the strobe rises
    if (ack_second) begin
      s_d.second = 1'b0;
      s_d.oe = 1'b1;
    end
    if (interrupt_acknowledge_n) begin
      s_d.oe = 1'b0;
    end
    // NMI holds the maskable request off so it is served first
    s_d.intr = (elig[0] != 8'h00) & ~nmi;
    // Reads: unmapped ports float high as on the ISA side
    if (io_rd) begin
      s_d.rdata = CPIC_UNMAPPED;
      for (int c = 0; c < 2; c++) begin
        if (io_addr == port_of(c, 2'h0)) begin
          s_d.rdata = s_q.rd_insvc[c] ? s_q.insvc[c] : pend[c];
        end
        if (io_addr == port_of(c, 2'h1)) begin
          s_d.rdata = s_q.imr[c];
        end
        if (io_addr == port_of(c, 2'h2)) begin
          s_d.rdata = s_q.sense[c];
        end
      end
      if (io_addr == CPIC_NMI_CTL) begin
        s_d.rdata = nb.ctl_rd;
      end
      if (io_addr == CPIC_NMI_MASK) begin
        s_d.rdata = nb.mask_rd;
      end
    end
  end

  // State register; all sense bits edge after reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.sense <= {CPIC_SENSE_RST, CPIC_SENSE_RST};
      s_q.imr <= {CPIC_IMR_RST, CPIC_IMR_RST};
      s_q.vbase <= {CPIC_VBASE_S_RST, CPIC_VBASE_M_RST};
      s_q.ack_n_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // NMI unit and its register strobes
  assign nb.ctl_wr = io_wr && io_addr == CPIC_NMI_CTL;
  assign nb.mask_wr = io_wr && io_addr == CPIC_NMI_MASK;
  assign nb.wdata = io_wdata;

  cpic_nmi u_nmi (
    .core_clk(core_clk),
    .nrst(nrst),
    .serr_n(serr_n),
    .channel_check_n(channel_check_n),
    .bus(nb),
    .nmi(nmi)
  );

  // Outputs straight from the state register
  assign intr = s_q.intr;
  assign ack_vector = s_q.vec;
  assign ack_vector_oe = s_q.oe;
  assign io_rdata = s_q.rdata;

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_first;
    ack_first;
  endsequence

  sequence s_pair;
    ack_first ##[1:300] ack_second;
  endsequence

  a_edge_no_repeat: assert property (
    (!s_q.sense[0][3] && s_q.prev[3] && raw[3] && !s_q.lat[0][3]) |=>
    !s_q.lat[0][3]) else $error("held line requested again");
  a_level_low_pend: assert property (
    (s_q.sense[0][3] && !raw[3]) |-> pend[0][3])
    else $error("low level not pending");
  a_level_bit_ignored: assert property (
    (io_wr && io_addr == CPIC_MASTER_CMD && io_wdata[CPIC_IW1_ID] &&
     io_wdata[CPIC_IW1_LEVEL]) |=> $stable(s_q.sense))
    else $error("bank level bit changed sense");
  a_cop_route_int: assert property (
    (!s_q.sense[1][5] && isa_clk_div[CPIC_DIV_COP] && cop_err_int &&
     !s_q.prev[13] && !io_wr && !ack_first) |=> s_q.lat[1][5])
    else $error("internal coprocessor request lost");
  a_mouse_route_pin: assert property (
    (!s_q.sense[1][4] && !isa_clk_div[CPIC_DIV_MOUSE] && mouse_request &&
     !s_q.prev[12] && !io_wr && !ack_first) |=> s_q.lat[1][4])
    else $error("mouse pin request lost");
  a_default_vec_seven: assert property (
    (s_first and (elig[0] == 8'h00 && !io_wr)) |=>
    (s_q.vec[2:0] == CPIC_DEFAULT_LINE && $stable(s_q.insvc)))
    else $error("default line 7 wrong");
  a_real_seven_insvc: assert property (
    (s_first and (elig[0] == 8'h80 && !s_q.aeoi[0] && !io_wr)) |=>
    s_q.insvc[0][7]) else $error("line 7 not in service");
  a_slave_vec_base: assert property (
    (s_first and (elig[0] == 8'h04 && elig[1] != 8'h00)) |=>
    (s_q.vec[7:3] == s_q.vbase[1])) else $error("slave vector wrong");
  a_vector_second: assert property (
    s_pair |=> ack_vector_oe) else $error("vector not driven");
  a_nmi_over_intr: assert property (
    nmi |=> !intr) else $error("maskable request beside nmi");
  a_intr_follows: assert property (
    (elig[0] != 8'h00 && !nmi) |=> intr) else $error("intr not raised");
endmodule : cpic_top

// ### inc/cpic_nmi_if.sv
// Register strobes between the decoder and the NMI unit
`timescale 1ns/1ps
interface cpic_nmi_if;
  logic ctl_wr;
  logic mask_wr;
  logic [7:0] wdata;
  logic [7:0] ctl_rd;
  logic [7:0] mask_rd;
  modport regs (output ctl_wr, mask_wr, wdata, input ctl_rd, mask_rd);
  modport unit (input ctl_wr, mask_wr, wdata, output ctl_rd, mask_rd);
endinterface : cpic_nmi_if

// ### inc/cpic_pkg.sv
// Constants and types of the cascaded interrupt block
package cpic_pkg;
  typedef logic [7:0] cpic_byte_type;
  typedef logic [15:0] cpic_addr_type;
  typedef enum logic [1:0] {CPIC_IDLE, CPIC_IW2, CPIC_IW3, CPIC_IW4}
    cpic_step_type;
  // I/O ports
  localparam cpic_addr_type CPIC_MASTER_CMD = 16'h0020;
  localparam cpic_addr_type CPIC_MASTER_DATA = 16'h0021;
  localparam cpic_addr_type CPIC_SLAVE_CMD = 16'h00a0;
  localparam cpic_addr_type CPIC_SLAVE_DATA = 16'h00a1;
  localparam cpic_addr_type CPIC_SENSE_MASTER = 16'h04d0;
  localparam cpic_addr_type CPIC_SENSE_SLAVE = 16'h04d1;
  localparam cpic_addr_type CPIC_NMI_CTL = 16'h0061;
  localparam cpic_addr_type CPIC_NMI_MASK = 16'h0070;
  localparam cpic_byte_type CPIC_UNMAPPED = 8'hff;
  // Command word fields
  localparam int CPIC_IW1_ID = 4;
  localparam int CPIC_IW1_LEVEL = 3;
  localparam int CPIC_IW1_SINGLE = 1;
  localparam int CPIC_IW1_IW4 = 0;
  localparam int CPIC_IW4_AEOI = 1;
  localparam int CPIC_OCW3_ID = 3;
  localparam int CPIC_OCW3_RR = 1;
  localparam int CPIC_OCW3_RIS = 0;
  localparam logic [2:0] CPIC_EOI_NSPEC = 3'h1;
  localparam logic [2:0] CPIC_EOI_SPEC = 3'h3;
  // Line assignment
  localparam int CPIC_IRQ_TIMER = 0;
  localparam int CPIC_CASCADE_LINE = 2;
  localparam int CPIC_IRQ_MOUSE = 12;
  localparam int CPIC_IRQ_COP = 13;
  localparam logic [2:0] CPIC_DEFAULT_LINE = 3'h7;
  localparam int CPIC_DIV_MOUSE = 4;
  localparam int CPIC_DIV_COP = 5;
  // NMI register fields
  localparam int CPIC_NMI_SERR_EN = 2;
  localparam int CPIC_NMI_CHK_EN = 3;
  localparam int CPIC_NMI_CHK_ST = 6;
  localparam int CPIC_NMI_SERR_ST = 7;
  localparam int CPIC_NMI_MASK_BIT = 7;
  // Reset values
  localparam cpic_byte_type CPIC_SENSE_RST = 8'h00;
  localparam cpic_byte_type CPIC_IMR_RST = 8'h00;
  localparam logic [4:0] CPIC_VBASE_M_RST = 5'h01;
  localparam logic [4:0] CPIC_VBASE_S_RST = 5'h0e;
  localparam logic [6:0] CPIC_RTC_ADDR_RST = 7'h00;
endpackage : cpic_pkg

// ### test/cpic_host.sv
// Host processor model: acknowledge cycles and NMI edge count
`timescale 1ns/1ps
module cpic_host (
  input wire logic core_clk,
  input wire logic intr,
  input wire cpic_pkg::cpic_byte_type ack_vector,
  input wire logic ack_vector_oe,
  input wire logic nmi,
  output logic interrupt_acknowledge_n
);
  import cpic_pkg::*;
  int nmi_edges = 0;
  initial interrupt_acknowledge_n = 1'b1;
  // The processor reacts to NMI rising edges only; counted at the edge
  // itself so a check just after the rise already sees it
  always @(posedge nmi) begin
    nmi_edges <= nmi_edges + 1;
  end
  // Two pulses; gap makes the host quick or slow
  task automatic ack(input int gap, output cpic_byte_type vec);
    int n;
    @(negedge core_clk);
    interrupt_acknowledge_n = 1'b0;
    repeat (2) @(negedge core_clk);
    interrupt_acknowledge_n = 1'b1;
    repeat (gap) @(negedge core_clk);
    interrupt_acknowledge_n = 1'b0;
    for (n = 0; n < 8 && ack_vector_oe !== 1'b1; n++) @(negedge core_clk);
    vec = (ack_vector_oe === 1'b1) ? ack_vector : 8'hxx;
    interrupt_acknowledge_n = 1'b1;
  endtask : ack
endmodule : cpic_host

// ### test/cpic_top_tb.sv
// Self-checking bench of the cascaded interrupt block
`timescale 1ns/1ps
module cpic_top_tb;
  import cpic_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  cpic_addr_type io_addr = 16'h0000;
  cpic_byte_type io_wdata = 8'h00;
  cpic_byte_type io_rdata, ack_vector, isa_clk_div = 8'h00;
  logic io_wr = 1'b0, io_rd = 1'b0;
  logic [15:0] ext_irq = 16'h0000;
  logic tmr0_out = 1'b0, coproc_pin = 1'b0, mouse_request = 1'b0;
  logic cop_err_int = 1'b0, mouse_int = 1'b0;
  logic serr_n = 1'b1, channel_check_n = 1'b1;
  logic ack_n, intr, ack_vector_oe, nmi;
  int n_mismatch = 0;
  int compares = 0;
  //////////////////////////////////////////////////////////////////////
  cpic_top dut_u (.core_clk(core_clk), .nrst(nrst), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata), .ext_irq(ext_irq), .tmr0_out(tmr0_out),
    .coproc_error_request_pin(coproc_pin), .mouse_request(mouse_request),
    .cop_err_int(cop_err_int), .mouse_int(mouse_int),
    .isa_clk_div(isa_clk_div), .serr_n(serr_n),
    .channel_check_n(channel_check_n),
    .interrupt_acknowledge_n(ack_n), .intr(intr),
    .ack_vector(ack_vector), .ack_vector_oe(ack_vector_oe), .nmi(nmi));
  cpic_host host_u (.core_clk(core_clk), .intr(intr),
    .ack_vector(ack_vector), .ack_vector_oe(ack_vector_oe), .nmi(nmi),
    .interrupt_acknowledge_n(ack_n));
  // 100 MHz clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Strobes are one cycle wide, launched on the falling edge
  task automatic wr(input cpic_addr_type a, input cpic_byte_type d);
    @(negedge core_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge core_clk);
    io_wr = 1'b0;
  endtask : wr
  // Extra cycle so the registered read data has landed
  task automatic rd(input cpic_addr_type a, input cpic_byte_type e,
                    input string nm);
    @(negedge core_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge core_clk);
    io_rd = 1'b0;
    @(negedge core_clk);
    chk(nm, e, io_rdata);
  endtask : rd
  // Bounded wait for intr (sel 0) or nmi (sel 1)
  task automatic wt(input bit sel, input logic e);
    int n;
    for (n = 0; n < 12 && (sel ? nmi : intr) !== e; n++)
      @(negedge core_clk);
    if (sel) chk("nmi", {7'h00, e}, {7'h00, nmi});
    else chk("intr", {7'h00, e}, {7'h00, intr});
  endtask : wt
  // No request may reach the processor for n cycles
  task automatic quiet(input int n);
    int hi = 0;
    repeat (n) @(negedge core_clk) if (intr !== 1'b0) hi++;
    chk("intr quiet", 8'h00, 8'(hi));
  endtask : quiet
  // Wait for the request, acknowledge, optionally end it
  task automatic svc(input string nm, input cpic_byte_type v,
                     input bit eoi);
    cpic_byte_type g;
    wt(1'b0, 1'b1);
    host_u.ack(2, g);
    chk(nm, v, g);
    if (eoi && v[3]) wr(CPIC_SLAVE_CMD, 8'h20);
    if (eoi) wr(CPIC_MASTER_CMD, 8'h20);
  endtask : svc
  task automatic src(input int k, input logic v);
    case (k)
      0: mouse_int = v;
      1: mouse_request = v;
      2: cop_err_int = v;
      default: coproc_pin = v;
    endcase
  endtask : src
  //////////////////////////////////////////////////////////////////////
  // Watchdog: whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end
  // Main sequence
  initial begin
    cpic_byte_type g;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    rd(CPIC_SENSE_MASTER, 8'h00, "sense m");
    rd(CPIC_SENSE_SLAVE, 8'h00, "sense s");
    rd(16'h0123, CPIC_UNMAPPED, "unmapped");
    rd(CPIC_NMI_MASK, 8'h80, "nmi mask");
    // Bank level bit set in both init words must be ignored
    wr(CPIC_MASTER_CMD, 8'h19);
    wr(CPIC_MASTER_DATA, 8'h20);
    wr(CPIC_MASTER_DATA, 8'h04);
    wr(CPIC_MASTER_DATA, 8'h01);
    wr(CPIC_SLAVE_CMD, 8'h19);
    wr(CPIC_SLAVE_DATA, 8'h28);
    wr(CPIC_SLAVE_DATA, 8'h02);
    wr(CPIC_SLAVE_DATA, 8'h01);
    rd(CPIC_MASTER_DATA, 8'h00, "mask m");
    // Edge line held high requests once only
    ext_irq[3] = 1'b1;
    svc("edge irq3", 8'h23, 1'b1);
    quiet(10);
    wr(CPIC_SENSE_MASTER, 8'h08);
    rd(CPIC_SENSE_MASTER, 8'h08, "sense m");
    wr(CPIC_SENSE_SLAVE, 8'hc0);
    rd(CPIC_SENSE_SLAVE, 8'hc0, "sense s");
    wr(CPIC_SENSE_SLAVE, 8'h00);
    // Level line: active low, source drops before EOI
    ext_irq[3] = 1'b0;
    svc("level irq3", 8'h23, 1'b0);
    ext_irq[3] = 1'b1;
    wr(CPIC_MASTER_CMD, 8'h20);
    quiet(6);
    wr(CPIC_SENSE_MASTER, 8'h00);
    ext_irq[3] = 1'b0;
    tmr0_out = 1'b1;
    svc("timer", 8'h20, 1'b1);
    tmr0_out = 1'b0;
    ext_irq[10] = 1'b1;
    svc("slave irq10", 8'h2a, 1'b1);
    ext_irq[10] = 1'b0;
    // Internal or pin source per divisor bit; the other is ignored
    for (int k = 0; k < 4; k++) begin
      isa_clk_div = (k == 0) ? 8'h10 : (k == 2) ? 8'h20 : 8'h00;
      src(k ^ 1, 1'b1);
      quiet(6);
      src(k ^ 1, 1'b0);
      src(k, 1'b1);
      svc("line 12/13", (k < 2) ? 8'h2c : 8'h2d, 1'b1);
      src(k, 1'b0);
    end
    // Request vanishes before the first pulse
    ext_irq[5] = 1'b1;
    wt(1'b0, 1'b1);
    ext_irq[5] = 1'b0;
    host_u.ack(4, g);
    chk("default", 8'h27, g);
    wr(CPIC_MASTER_CMD, 8'h0b);
    rd(CPIC_MASTER_CMD, 8'h00, "in-service default");
    ext_irq[7] = 1'b1;
    svc("irq7", 8'h27, 1'b0);
    rd(CPIC_MASTER_CMD, 8'h80, "in-service irq7");
    wr(CPIC_MASTER_CMD, 8'h20);
    ext_irq[7] = 1'b0;
    // NMI sources, mask, and precedence over a pending line
    wr(CPIC_NMI_MASK, 8'h85);
    rd(CPIC_NMI_MASK, 8'h85, "nmi rtc");
    wr(CPIC_NMI_CTL, 8'h0c);
    wr(CPIC_NMI_MASK, 8'h00);
    serr_n = 1'b0;
    ext_irq[4] = 1'b1;
    wt(1'b1, 1'b1);
    quiet(5);
    rd(CPIC_NMI_CTL, 8'h8c, "nmi status");
    serr_n = 1'b1;
    wr(CPIC_NMI_MASK, 8'h80);
    wt(1'b1, 1'b0);
    wr(CPIC_NMI_MASK, 8'h00);
    wt(1'b1, 1'b1);
    chk("nmi edges", 8'h02, 8'(host_u.nmi_edges));
    wr(CPIC_NMI_CTL, 8'h08);
    wt(1'b1, 1'b0);
    channel_check_n = 1'b0;
    wt(1'b1, 1'b1);
    rd(CPIC_NMI_CTL, 8'h48, "nmi status");
    wr(CPIC_NMI_CTL, 8'h00);
    channel_check_n = 1'b1;
    wt(1'b1, 1'b0);
    svc("irq4", 8'h24, 1'b1);
    ext_irq[4] = 1'b0;
    chk("nmi edges", 8'h03, 8'(host_u.nmi_edges));
    summarize();
  end
endmodule : cpic_top_tb
